/* File: pidsel_top.sv */
// The Avalon-MM slave port and the register addresses were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
// Contract
// - Direction mask: bit clear forward, set reverse
// - Bit 0 dominant, bit n segment n (code: bit 0 has no priority, it steers segment 0 only)
// - Mask used only while sequencer on
// - Mode 0 keeps loop inactive
// - Mode 1 keeps loop always active
// - Mode 2 follows loop enable terminal
// - Polarity selects accelerate/decelerate sense
// - Target from numeric, voltage or current
// - Feedback from voltage, current or differences
// - Numeric full scale equals +10 V
// - Upper alarm when feedback above level
// - Evaluate every 10 ms, clamp step
// - Lower alarm when feedback below level
module pidsel_top
   import pidsel_pkg::*;
#(
   parameter int EVAL_CNT = EVAL_CYCLES,
   parameter int AW = ADC_BITS
) (
   // System
   input wire logic clk_sys,
   input wire logic reset,
   // Avalon-MM slave
   input wire logic [5:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // Sequencer side
   input wire logic program_sequencer_on,
   input wire logic [3:0] segment_index,
   // Analogue inputs and terminals
   input wire logic [AW-1:0] voltage_analog_input,
   input wire logic [AW-1:0] current_analog_input,
   input wire logic loop_enable_terminal,
   // Results
   output logic run_reverse,
   output logic loop_active,
   output logic eval_tick,
   output logic step_valid,
   output logic step_up,
   output logic [15:0] step_size,
   output logic upper_alarm,
   output logic lower_alarm,
   output logic irq
);
   localparam logic [31:0] EVAL_LAST = 32'(EVAL_CNT - 1);
   // ==========================================================
   // Registers
   logic [15:0] dir_mask_q, en_mode_q, polarity_q, tgt_sel_q, fb_sel_q;
   logic [15:0] num_tgt_q, upper_q, lower_q, max_step_q;
   logic [IRQ_BITS-1:0] irq_stat_q, irq_mask_q;
   logic [31:0] tmr_q;
   pidsel_pair_s pair;
   // ==========================================================
   // Bus decode; every access answers one cycle after the request
   wire logic req = (avs_read | avs_write) & avs_waitrequest;
   // Writes land only at the edge that sees waitrequest low
   wire logic wr = avs_write & ~avs_waitrequest;
   wire logic [15:0] wd = avs_writedata[15:0];
   wire logic be_ok = avs_byteenable[0] | avs_byteenable[1];
   wire logic [15:0] be_m = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
   // Out-of-range values fall back to 0
   wire logic [1:0] mode_f = (en_mode_q > 16'h2) ? EN_OFF
      : en_mode_q[1:0];
   wire logic [1:0] tgt_f = (tgt_sel_q > 16'h2) ? TGT_NUMERIC
      : tgt_sel_q[1:0];
   wire logic [1:0] fb_f = (fb_sel_q > 16'h3) ? FB_VOLT
      : fb_sel_q[1:0];
   pidsel_cfg_s cfg;
   assign cfg = {mode_f, polarity_q[0], tgt_f, fb_f};
   // ==========================================================
   // Loop enable decision
   wire logic act_w = (mode_f == EN_ALWAYS) |
      ((mode_f == EN_TERMINAL) & loop_enable_terminal);
   wire logic tick_w = (tmr_q == EVAL_LAST);
   // ==========================================================
   // Comparison on the evaluation tick
   wire logic signed [AW+1:0] err = pair.target - pair.feedback;
   wire logic [AW:0] err_abs = err[AW+1] ? (AW+1)'(0) - err[AW:0]
      : err[AW:0];
   // Feedback relative to full scale, in tenths of a percent
   wire logic signed [AW:0] fb = pair.feedback;
   wire logic [AW+10:0] fb_prod = fb[AW] ? '0 : (AW+11)'(fb) * 11'd1000;
   wire logic [AW+10:0] fb_pm = fb_prod / (AW+11)'((1 << AW) - 1);
   wire logic up_w = {5'h0, fb_pm} > (AW+16)'(upper_q);
   wire logic lo_w = fb[AW] | ({5'h0, fb_pm} < (AW+16)'(lower_q));
   // Positive mode: feedback above target means slow down
   wire logic fb_above = err[AW+1];
   wire logic go_up = cfg.polarity ? ~fb_above : fb_above;
   // Saturate only past the 16-bit step field, not at the input range
   wire logic [15:0] err16 = (32'(err_abs) > 32'h0000_ffff) ? 16'hffff
      : 16'(err_abs);
   wire logic [15:0] step_w = (err16 > max_step_q) ? max_step_q
      : err16;
   wire logic dir_bit = dir_mask_q[segment_index];
   wire logic [IRQ_BITS-1:0] ev = {tick_w & act_w, tick_w & lo_w,
      tick_w & up_w, act_w & ~loop_active};
   wire logic [IRQ_BITS-1:0] w1c = (wr & avs_address == OFS_IRQ_STAT
      & avs_byteenable[0]) ? wd[IRQ_BITS-1:0] : '0;
   wire logic [31:0] rd_w =
      (avs_address == OFS_DIR_MASK) ? {16'h0, dir_mask_q} :
      (avs_address == OFS_EN_MODE) ? {16'h0, en_mode_q} :
      (avs_address == OFS_POLARITY) ? {16'h0, polarity_q} :
      (avs_address == OFS_TGT_SEL) ? {16'h0, tgt_sel_q} :
      (avs_address == OFS_FB_SEL) ? {16'h0, fb_sel_q} :
      (avs_address == OFS_NUM_TGT) ? {16'h0, num_tgt_q} :
      (avs_address == OFS_UPPER) ? {16'h0, upper_q} :
      (avs_address == OFS_LOWER) ? {16'h0, lower_q} :
      (avs_address == OFS_MAX_STEP) ? {16'h0, max_step_q} :
      (avs_address == OFS_STATUS) ? {28'h0, 1'b0, lower_alarm,
         upper_alarm, loop_active} :
      (avs_address == OFS_IRQ_STAT) ? {28'h0, irq_stat_q} :
      (avs_address == OFS_IRQ_MASK) ? {28'h0, irq_mask_q} :
      (avs_address == OFS_OUT_DIR) ? {31'h0, run_reverse} : 32'h0;

   pidsel_src_mux #(.AW(AW)) u_mux (
      .clk_sys(clk_sys),
      .reset(reset),
      .cfg(cfg),
      .num_target(num_tgt_q),
      .volt_in(voltage_analog_input),
      .curr_in(current_analog_input),
      .pair(pair)
   );

   // ==========================================================
   // Configuration storage
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         dir_mask_q <= RST_DIR_MASK;
         en_mode_q <= RST_EN_MODE;
         polarity_q <= RST_POLARITY;
         tgt_sel_q <= RST_TGT_SEL;
         fb_sel_q <= RST_FB_SEL;
         num_tgt_q <= RST_NUM_TGT;
         upper_q <= RST_UPPER;
         lower_q <= RST_LOWER;
         max_step_q <= RST_MAX_STEP;
         irq_mask_q <= '0;
      end else if (wr & be_ok) begin
         case (avs_address)
            OFS_DIR_MASK: dir_mask_q <= (dir_mask_q & ~be_m) | (wd & be_m);
            OFS_EN_MODE: en_mode_q <= (en_mode_q & ~be_m) | (wd & be_m);
            OFS_POLARITY: polarity_q <= (polarity_q & ~be_m) | (wd & be_m);
            OFS_TGT_SEL: tgt_sel_q <= (tgt_sel_q & ~be_m) | (wd & be_m);
            OFS_FB_SEL: fb_sel_q <= (fb_sel_q & ~be_m) | (wd & be_m);
            OFS_NUM_TGT: num_tgt_q <= (num_tgt_q & ~be_m) | (wd & be_m);
            OFS_UPPER: upper_q <= (upper_q & ~be_m) | (wd & be_m);
            OFS_LOWER: lower_q <= (lower_q & ~be_m) | (wd & be_m);
            OFS_MAX_STEP: max_step_q <= (max_step_q & ~be_m) | (wd & be_m);
            OFS_IRQ_MASK: irq_mask_q <= wd[IRQ_BITS-1:0];
            default: ;
         endcase
      end
   end

   // ==========================================================
   // Bus answer, timer, outputs
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         avs_waitrequest <= 1'b1;
         avs_readdata <= 32'h0;
         tmr_q <= 32'h0;
         loop_active <= 1'b0;
         eval_tick <= 1'b0;
         step_valid <= 1'b0;
         step_up <= 1'b0;
         step_size <= 16'h0;
         upper_alarm <= 1'b0;
         lower_alarm <= 1'b0;
         run_reverse <= 1'b0;
         irq_stat_q <= '0;
         irq <= 1'b0;
      end else begin
         avs_waitrequest <= ~req;
         avs_readdata <= rd_w;
         tmr_q <= tick_w ? 32'h0 : tmr_q + 32'h1;
         loop_active <= act_w;
         eval_tick <= tick_w;
         step_valid <= tick_w & act_w;
         run_reverse <= program_sequencer_on & dir_bit;
         if (tick_w) begin
            upper_alarm <= up_w;
            lower_alarm <= lo_w;
            step_up <= go_up;
            step_size <= act_w ? step_w : 16'h0;
         end
         // Set beats clear
         irq_stat_q <= (irq_stat_q & ~w1c) | ev;
         irq <= |(((irq_stat_q & ~w1c) | ev) & irq_mask_q);
      end
   end
   // ==========================================================
   // Checks
   property p_mode0;
      @(posedge clk_sys) disable iff (reset)
      (en_mode_q == 16'h0) |=> !loop_active;
   endproperty
   a_mode0: assert property (p_mode0) else $error("mode 0 active");
   property p_mode1;
      @(posedge clk_sys) disable iff (reset)
      (en_mode_q == 16'h1) |=> loop_active;
   endproperty
   a_mode1: assert property (p_mode1) else $error("mode 1 idle");
   property p_mode2;
      @(posedge clk_sys) disable iff (reset)
      (en_mode_q == 16'h2) |=> (loop_active == $past(loop_enable_terminal));
   endproperty
   a_mode2: assert property (p_mode2) else $error("mode 2 term");
   property p_dir;
      @(posedge clk_sys) disable iff (reset)
      1'b1 |=> run_reverse == ($past(program_sequencer_on)
         & $past(dir_mask_q[segment_index]));
   endproperty
   a_dir: assert property (p_dir) else $error("dir mismatch");
   property p_seq_off;
      @(posedge clk_sys) disable iff (reset)
      !program_sequencer_on |=> !run_reverse;
   endproperty
   a_seq_off: assert property (p_seq_off) else $error("mask off");
   property p_clamp;
      @(posedge clk_sys) disable iff (reset)
      step_valid |-> step_size <= $past(max_step_q);
   endproperty
   a_clamp: assert property (p_clamp) else $error("step clamp");
   property p_alarm_hold;
      @(posedge clk_sys) disable iff (reset)
      !eval_tick |-> $stable(upper_alarm) && $stable(lower_alarm);
   endproperty
   a_alarm_hold: assert property (p_alarm_hold)
      else $error("alarm");
   property p_upper;
      @(posedge clk_sys) disable iff (reset)
      tick_w && up_w |=> upper_alarm;
   endproperty
   a_upper: assert property (p_upper) else $error("upper miss");
   property p_lower;
      @(posedge clk_sys) disable iff (reset)
      tick_w && lo_w |=> lower_alarm;
   endproperty
   a_lower: assert property (p_lower) else $error("lower miss");
   property p_bus;
      @(posedge clk_sys) disable iff (reset)
      (avs_read | avs_write) && avs_waitrequest |=> !avs_waitrequest;
   endproperty
   a_bus: assert property (p_bus) else $error("bus late");
   c_step: cover property (@(posedge clk_sys) step_valid && step_up);
   c_up: cover property (@(posedge clk_sys) upper_alarm);
   c_rev: cover property (@(posedge clk_sys) run_reverse);
   c_irq: cover property (@(posedge clk_sys) irq);
endmodule
`default_nettype wire

/* File: pidsel_pkg.sv */
package pidsel_pkg;
   // ==========================================================
   // Register map (byte addresses, one 32-bit word each)
   localparam logic [5:0] OFS_DIR_MASK = 6'h00;
   localparam logic [5:0] OFS_EN_MODE = 6'h04;
   localparam logic [5:0] OFS_POLARITY = 6'h08;
   localparam logic [5:0] OFS_TGT_SEL = 6'h0c;
   localparam logic [5:0] OFS_FB_SEL = 6'h10;
   localparam logic [5:0] OFS_NUM_TGT = 6'h14;
   localparam logic [5:0] OFS_UPPER = 6'h18;
   localparam logic [5:0] OFS_LOWER = 6'h1c;
   localparam logic [5:0] OFS_MAX_STEP = 6'h20;
   localparam logic [5:0] OFS_STATUS = 6'h24;
   localparam logic [5:0] OFS_IRQ_STAT = 6'h28;
   localparam logic [5:0] OFS_IRQ_MASK = 6'h2c;
   localparam logic [5:0] OFS_OUT_DIR = 6'h30;
   // ==========================================================
   // Reset values
   localparam logic [15:0] RST_DIR_MASK = 16'h0000;
   localparam logic [15:0] RST_EN_MODE = 16'h0000;
   localparam logic [15:0] RST_POLARITY = 16'h0000;
   localparam logic [15:0] RST_TGT_SEL = 16'h0000;
   localparam logic [15:0] RST_FB_SEL = 16'h0000;
   localparam logic [15:0] RST_NUM_TGT = 16'h0000;
   localparam logic [15:0] RST_UPPER = 16'h0000;
   localparam logic [15:0] RST_LOWER = 16'h0000;
   // Step limit reset 0.10 Hz in 0.01 Hz units
   localparam logic [15:0] RST_MAX_STEP = 16'h000a;
   // ==========================================================
   // Field encodings
   localparam logic [1:0] EN_OFF = 2'h0;
   localparam logic [1:0] EN_ALWAYS = 2'h1;
   localparam logic [1:0] EN_TERMINAL = 2'h2;
   localparam logic [1:0] TGT_NUMERIC = 2'h0;
   localparam logic [1:0] TGT_VOLT = 2'h1;
   localparam logic [1:0] TGT_CURR = 2'h2;
   localparam logic [1:0] FB_VOLT = 2'h0;
   localparam logic [1:0] FB_CURR = 2'h1;
   localparam logic [1:0] FB_V_MINUS_C = 2'h2;
   localparam logic [1:0] FB_C_MINUS_V = 2'h3;
   // Status / interrupt bit positions
   localparam int ST_ACTIVE = 0;
   localparam int ST_UPPER = 1;
   localparam int ST_LOWER = 2;
   localparam int ST_TICK = 3;
   localparam int IRQ_BITS = 4;
   // Alarm levels count 0..1000 for 0.0..100.0 %
   localparam logic [15:0] ALARM_FULL = 16'd1000;
   // ==========================================================
   // Timing
   localparam int CLK_HZ = 50_000_000;
   localparam int EVAL_MS = 10;
   localparam int EVAL_CYCLES = (CLK_HZ / 1000) * EVAL_MS;
   localparam int ADC_BITS = 12;
   // ==========================================================
   // Carriers
   typedef struct packed {
      logic [1:0] mode;
      logic polarity;
      logic [1:0] tgt_sel;
      logic [1:0] fb_sel;
   } pidsel_cfg_s;
   typedef struct packed {
      logic signed [ADC_BITS:0] target;
      logic signed [ADC_BITS:0] feedback;
   } pidsel_pair_s;
endpackage

/* File: pidsel_src_mux.sv */
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Target and feedback source selection, registered
module pidsel_src_mux
   import pidsel_pkg::*;
#(
   parameter int AW = ADC_BITS
) (
   // System
   input wire logic clk_sys,
   input wire logic reset,
   // Configuration
   input wire pidsel_cfg_s cfg,
   input wire logic [15:0] num_target,
   // Analogue samples, full scale = +10 V / 20 mA
   input wire logic [AW-1:0] volt_in,
   input wire logic [AW-1:0] curr_in,
   // Selected pair
   output pidsel_pair_s pair
);
   wire logic signed [AW:0] v_s = {1'b0, volt_in};
   wire logic signed [AW:0] c_s = {1'b0, curr_in};
   // Numeric 0..1000 scaled to the +10 V code: n*(2^AW-1)/1000
   wire logic [AW+15:0] num_prod = (AW+16)'(num_target)
      * (AW+16)'((1 << AW) - 1);
   wire logic [AW+15:0] num_scl = num_prod / 16'd1000;
   wire logic [AW-1:0] num_code = (num_target >= ALARM_FULL) ?
      {AW{1'b1}} : num_scl[AW-1:0];
   wire logic signed [AW:0] tgt_w =
      (cfg.tgt_sel == TGT_VOLT) ? v_s :
      (cfg.tgt_sel == TGT_CURR) ? c_s :
      $signed({1'b0, num_code});
   wire logic signed [AW:0] fb_w =
      (cfg.fb_sel == FB_CURR) ? c_s :
      (cfg.fb_sel == FB_V_MINUS_C) ? v_s - c_s :
      (cfg.fb_sel == FB_C_MINUS_V) ? c_s - v_s : v_s;
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         pair <= '0;
      end else begin
         pair.target <= tgt_w;
         pair.feedback <= fb_w;
      end
   end
endmodule
`default_nettype wire

/* File: pidsel_plant.sv */
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Analogue sources and loop enable terminal
module pidsel_plant
   import pidsel_pkg::*;
(
   // System
   input wire logic clk_sys,
   // Requested levels
   input wire logic [ADC_BITS-1:0] volt_req,
   input wire logic [ADC_BITS-1:0] curr_req,
   input wire logic en_req,
   // Toward the block
   output logic [ADC_BITS-1:0] voltage_analog_input,
   output logic [ADC_BITS-1:0] current_analog_input,
   output logic loop_enable_terminal
);
   // Converter results land one sample late, as a real converter would
   always @(posedge clk_sys) begin
      voltage_analog_input <= volt_req;
      current_analog_input <= curr_req;
      loop_enable_terminal <= en_req;
   end
endmodule
`default_nettype wire

/* File: pidsel_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module testbench;
   import pidsel_pkg::*;
   localparam int EVAL_N = 20;
   logic clk_sys, reset, avs_read, avs_write, avs_waitrequest;
   logic [5:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata, rd;
   logic [3:0] avs_byteenable, seg;
   logic seq_on, en_req, en_in, run_reverse, loop_active, eval_tick;
   logic step_valid, step_up, upper_alarm, lower_alarm, irq;
   logic [ADC_BITS-1:0] volt_req, curr_req, v_in, c_in;
   logic [15:0] step_size;
   int err_total, checks, mx;
   // ==========================================================
   // Design and far side
   pidsel_top #(.EVAL_CNT(EVAL_N)) i_dut (.clk_sys(clk_sys), .reset(reset),
      .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .program_sequencer_on(seq_on),
      .segment_index(seg), .voltage_analog_input(v_in),
      .current_analog_input(c_in), .loop_enable_terminal(en_in),
      .run_reverse(run_reverse), .loop_active(loop_active),
      .eval_tick(eval_tick), .step_valid(step_valid), .step_up(step_up),
      .step_size(step_size), .upper_alarm(upper_alarm),
      .lower_alarm(lower_alarm), .irq(irq));
   pidsel_plant i_plant (.clk_sys(clk_sys), .volt_req(volt_req),
      .curr_req(curr_req), .en_req(en_req), .voltage_analog_input(v_in),
      .current_analog_input(c_in), .loop_enable_terminal(en_in));
   always #10 clk_sys = ~clk_sys;
   // ==========================================================
   // Shared tasks
   task report_and_stop;
      if (err_total == 0 && checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         err_total++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task wr(input logic [5:0] a, input logic [15:0] d);
      avs_address <= a;
      avs_writedata <= {16'h0000, d};
      avs_write <= 1'b1;
      @(posedge clk_sys);
      while (avs_waitrequest !== 1'b0) @(posedge clk_sys);
      avs_write <= 1'b0;
      @(posedge clk_sys);
   endtask
   task rd_chk(input logic [5:0] a, input logic [31:0] exp);
      avs_address <= a;
      avs_read <= 1'b1;
      @(posedge clk_sys);
      while (avs_waitrequest !== 1'b0) @(posedge clk_sys);
      rd = avs_readdata;
      avs_read <= 1'b0;
      @(posedge clk_sys);
      chk(rd, exp);
   endtask
   // Alarms and steps move only on ticks, so wait out three periods
   task settle;
      repeat (3 * EVAL_N) @(posedge clk_sys);
   endtask
   // ==========================================================
   // Scenarios
   task t_regs;
      rd_chk(OFS_DIR_MASK, 32'h0000_0000);
      rd_chk(OFS_EN_MODE, 32'h0000_0000);
      rd_chk(OFS_POLARITY, 32'h0000_0000);
      rd_chk(OFS_TGT_SEL, 32'h0000_0000);
      rd_chk(OFS_FB_SEL, 32'h0000_0000);
      rd_chk(OFS_UPPER, 32'h0000_0000);
      rd_chk(OFS_MAX_STEP, {16'h0000, RST_MAX_STEP});
      wr(OFS_UPPER, 16'h03e8);
      rd_chk(OFS_UPPER, 32'h0000_03e8);
      rd_chk(6'h3c, 32'h0000_0000);
   endtask
   task t_dir;
      logic [15:0] m;
      m = 16'h800a;
      wr(OFS_DIR_MASK, m);
      seq_on <= 1'b1;
      for (int s = 0; s < 16; s++) begin
         seg <= 4'(s);
         repeat (3) @(posedge clk_sys);
         chk(32'(run_reverse), 32'(m[s]));
      end
      seq_on <= 1'b0;
      seg <= 4'h1;
      repeat (3) @(posedge clk_sys);
      chk(32'(run_reverse), 32'h0000_0000);
   endtask
   task t_mode;
      wr(OFS_EN_MODE, 16'h0000);
      en_req <= 1'b1;
      settle;
      chk(32'(loop_active), 32'h0000_0000);
      wr(OFS_EN_MODE, 16'h0001);
      en_req <= 1'b0;
      settle;
      chk(32'(loop_active), 32'h0000_0001);
      wr(OFS_EN_MODE, 16'h0002);
      settle;
      chk(32'(loop_active), 32'h0000_0000);
      en_req <= 1'b1;
      settle;
      chk(32'(loop_active), 32'h0000_0001);
      wr(OFS_EN_MODE, 16'h0003);
      settle;
      chk(32'(loop_active), 32'h0000_0000);
   endtask
   task t_tick;
      int n;
      while (eval_tick !== 1'b1) @(posedge clk_sys);
      @(posedge clk_sys);
      n = 1;
      while (eval_tick !== 1'b1 && n < 100) begin
         @(posedge clk_sys);
         n++;
      end
      chk(32'(n), 32'(EVAL_N));
      chk(32'(step_valid), 32'h0000_0000);
   endtask
   task step_case(input logic [15:0] ts, input logic [15:0] fs,
         input logic pol, input logic [15:0] num, input int v, input int c,
         input int t);
      int f, e;
      wr(OFS_TGT_SEL, ts);
      wr(OFS_FB_SEL, fs);
      wr(OFS_POLARITY, {15'h0000, pol});
      wr(OFS_NUM_TGT, num);
      volt_req <= 12'(v);
      curr_req <= 12'(c);
      settle;
      f = (fs == 1) ? c : (fs == 2) ? v - c : (fs == 3) ? c - v : v;
      e = (t > f) ? t - f : f - t;
      if (e > mx) e = mx;
      while (step_valid !== 1'b1) @(posedge clk_sys);
      chk(32'(step_size), 32'(e));
      chk(32'(step_up), 32'(pol ? f < t : f > t));
   endtask
   task t_step;
      wr(OFS_EN_MODE, 16'h0001);
      wr(OFS_MAX_STEP, 16'hffff);
      mx = 65535;
      step_case(16'h0, 16'h0, 1'b1, 16'h03e8, 1000, 0, 4095);
      step_case(16'h1, 16'h1, 1'b0, 16'h0000, 3000, 500, 3000);
      step_case(16'h2, 16'h2, 1'b1, 16'h0000, 2600, 2000, 2000);
      step_case(16'h2, 16'h3, 1'b0, 16'h0000, 400, 1000, 1000);
      step_case(16'h3, 16'h4, 1'b1, 16'h0000, 700, 0, 0);
      wr(OFS_MAX_STEP, 16'h0064);
      mx = 100;
      step_case(16'h0, 16'h0, 1'b1, 16'h03e8, 1000, 0, 4095);
   endtask
   task t_alarm;
      wr(OFS_FB_SEL, 16'h0000);
      wr(OFS_UPPER, 16'h01f4);
      wr(OFS_LOWER, 16'h00c8);
      wr(OFS_IRQ_MASK, 16'h0002);
      volt_req <= 12'hdac;
      settle;
      chk(32'(upper_alarm), 32'h0000_0001);
      chk(32'(lower_alarm), 32'h0000_0000);
      chk(32'(irq), 32'h0000_0001);
      volt_req <= 12'h7d0;
      settle;
      chk(32'(upper_alarm), 32'h0000_0000);
      wr(OFS_IRQ_STAT, 16'h000f);
      repeat (2) @(posedge clk_sys);
      chk(32'(irq), 32'h0000_0000);
      volt_req <= 12'h12c;
      settle;
      chk(32'(lower_alarm), 32'h0000_0001);
      wr(OFS_IRQ_MASK, 16'h0000);
      volt_req <= 12'hdac;
      settle;
      chk(32'(irq), 32'h0000_0000);
      rd_chk(OFS_STATUS, 32'h0000_0003);
   endtask
   // ==========================================================
   // Main sequence and watchdog
   initial begin
      clk_sys = 1'b0;
      reset = 1'b1;
      avs_address = 6'h00;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0000_0000;
      avs_byteenable = 4'hf;
      seq_on = 1'b0;
      seg = 4'h0;
      en_req = 1'b0;
      volt_req = 12'h000;
      curr_req = 12'h000;
      err_total = 0;
      checks = 0;
      mx = 0;
      repeat (10) @(posedge clk_sys);
      reset <= 1'b0;
      @(posedge clk_sys);
      t_regs;
      t_dir;
      t_mode;
      t_tick;
      t_step;
      t_alarm;
      report_and_stop;
   end
   initial begin
      repeat (20000) @(posedge clk_sys);
      err_total++;
      report_and_stop;
   end
endmodule
`default_nettype wire
